// ---- hdl/sdc_pkg.sv ----
package sdc_pkg;
   localparam int ROW_W = 12;
   localparam int COL_W = 8;
   localparam int DQ_W = 16;
   localparam int BANKS = 4;
   localparam int DEPTH = 256;
   // Mode word fields
   localparam int MODE_BL_LSB = 0;
   localparam int MODE_BT_BIT = 3;
   localparam int MODE_CL_LSB = 4;
   localparam int PRE_BIT = 10;
   localparam logic [2:0] BL_FULL = 3'h7;
   localparam logic [2:0] CL_RESET = 3'h2;
   localparam logic [ROW_W-1:0] MODE_RESET = 12'h020;
   // Refresh: 4096 cycles per 64 ms
   localparam int REF_COUNT = 4096;
   localparam int REF_WINDOW_US = 64000;
   localparam int CLK_MHZ = 125;
   localparam int REF_GAP_CYC = (REF_WINDOW_US * CLK_MHZ) / REF_COUNT;
   localparam logic [10:0] REF_GAP = 11'(REF_GAP_CYC);
   localparam logic [3:0] PRE_DELAY = 4'h2;
   localparam logic [3:0] ACT_DELAY = 4'h2;
   typedef enum logic [3:0] {
      SDC_CMD_NOP = 4'h7,
      SDC_CMD_ACT = 4'h3,
      SDC_CMD_RD = 4'h5,
      SDC_CMD_WR = 4'h4,
      SDC_CMD_PRE = 4'h2,
      SDC_CMD_REF = 4'h1,
      SDC_CMD_MRS = 4'h0,
      SDC_CMD_BST = 4'h6
   } sdc_cmd_t;
endpackage

// ---- hdl/sdc_if.sv ----
`timescale 1ns/1ps
interface sdc_if;
   logic cke;
   logic cs_n;
   logic ras_n;
   logic cas_n;
   logic we_n;
   logic bank_sel_lo;
   logic bank_sel_hi;
   logic [sdc_pkg::ROW_W-1:0] addr;
   logic low_byte_mask;
   logic high_byte_mask;
   logic [sdc_pkg::DQ_W-1:0] data_lines_ctl;
   logic data_lines_ctl_oe;
   logic [sdc_pkg::DQ_W-1:0] data_lines_mem;
   logic [1:0] data_lines_mem_oe;
   logic [sdc_pkg::DQ_W-1:0] data_lines;
   assign data_lines[7:0] = data_lines_ctl_oe ? data_lines_ctl[7:0] :
      data_lines_mem_oe[0] ? data_lines_mem[7:0] : 8'h00;
   assign data_lines[15:8] = data_lines_ctl_oe ? data_lines_ctl[15:8] :
      data_lines_mem_oe[1] ? data_lines_mem[15:8] : 8'h00;
   modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank_sel_lo, bank_sel_hi, addr,
      low_byte_mask, high_byte_mask, data_lines, output data_lines_mem, data_lines_mem_oe);
   modport ctl (output cke, cs_n, ras_n, cas_n, we_n, bank_sel_lo, bank_sel_hi, addr,
      low_byte_mask, high_byte_mask, data_lines_ctl, data_lines_ctl_oe, input data_lines);
endinterface

// ---- hdl/sdc_burst_addr.sv ----
`timescale 1ns/1ps
module sdc_burst_addr (
   input wire logic [sdc_pkg::COL_W-1:0] start_col,
   input wire logic [sdc_pkg::COL_W-1:0] step,
   input wire logic [2:0] burst_len,
   input wire logic interleave,
   output logic [sdc_pkg::COL_W-1:0] col
);
   logic [sdc_pkg::COL_W-1:0] wrap_mask;
   logic [sdc_pkg::COL_W-1:0] low_part;
   always_comb begin
      case (burst_len)
         3'h0: wrap_mask = 8'h00;
         3'h1: wrap_mask = 8'h01;
         3'h2: wrap_mask = 8'h03;
         3'h3: wrap_mask = 8'h07;
         default: wrap_mask = 8'hFF;
      endcase
      // Interleave for every length code but full page; full page is always linear
      if (interleave && burst_len != sdc_pkg::BL_FULL) begin
         low_part = (start_col ^ step) & wrap_mask;
      end else begin
         low_part = (start_col + step) & wrap_mask;
      end
      col = (start_col & ~wrap_mask) | low_part;
   end
endmodule

// ---- hdl/sdc_mem.sv ----
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module sdc_mem (
   input wire logic clk,
   input wire logic rst,
   sdc_if.mem bus,
   output logic [3:0] bank_open,
   output logic power_down
);
   // Storage is a small window; row bits fold into a short index
   typedef struct packed {
      logic [11:0] mode;
      logic [3:0] open;
      logic [3:0][11:0] row;
      logic busy;
      logic wr;
      logic [1:0] bank;
      logic [7:0] col;
      logic [7:0] step;
      logic auto_pre;
      logic [2:0][17:0] rpipe;
      logic pd;
      logic [1:0] out_oe;
      logic [15:0] out_d;
      logic [3:0] open_q;
   } sdc_mem_st_t;
   sdc_mem_st_t s_reg;
   sdc_mem_st_t s_next;
   logic [15:0] mem_reg [sdc_pkg::DEPTH];
   logic [7:0] cur_col;
   logic [2:0] blen;
   logic [3:0] cmd;
   logic [1:0] bsel;
   logic burst_last;
   logic [7:0] idx;
   logic do_write;
   logic [2:0] cl;
   sdc_burst_addr u_addr (
      .start_col(s_reg.col),
      .step(s_reg.step),
      .burst_len(blen),
      .interleave(s_reg.mode[sdc_pkg::MODE_BT_BIT]),
      .col(cur_col)
   );
   assign blen = s_reg.mode[sdc_pkg::MODE_BL_LSB +: 3];
   assign cl = s_reg.mode[sdc_pkg::MODE_CL_LSB +: 3];
   assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
   assign bsel = {bus.bank_sel_hi, bus.bank_sel_lo};
   assign idx = cur_col ^ s_reg.row[s_reg.bank][7:0] ^ {6'h00, s_reg.bank};
   always_comb begin
      case (blen)
         3'h0: burst_last = 1'b1;
         3'h1: burst_last = s_reg.step == 8'h01;
         3'h2: burst_last = s_reg.step == 8'h03;
         3'h3: burst_last = s_reg.step == 8'h07;
         default: burst_last = 1'b0;
      endcase
   end
   assign do_write = !s_reg.pd && bus.cke && s_reg.busy && s_reg.wr;
   always_comb begin
      s_next = s_reg;
      if (s_reg.pd) begin
         // Clock enable is acted on with no command in flight
         if (bus.cke) begin
            s_next.pd = 1'b0;
         end
      end else if (!bus.cke) begin
         // Entry only legal with all banks idle
         if (s_reg.open == 4'h0 && !s_reg.busy) begin
            s_next.pd = 1'b1;
            s_next.out_oe = 2'h0;
         end
      end else begin
         s_next.rpipe = {s_reg.rpipe[1:0], 18'h00000};
         if (s_reg.busy) begin
            if (!s_reg.wr) begin
               s_next.rpipe[0] = {2'b10, mem_reg[idx]};
            end
            s_next.step = s_reg.step + 8'h01;
            if (burst_last) begin
               s_next.busy = 1'b0;
               if (s_reg.auto_pre) begin
                  s_next.open[s_reg.bank] = 1'b0;
               end
            end
         end
         case (cmd)
            sdc_pkg::SDC_CMD_ACT: begin
               s_next.open[bsel] = 1'b1;
               s_next.row[bsel] = bus.addr;
            end
            sdc_pkg::SDC_CMD_PRE: begin
               if (bus.addr[sdc_pkg::PRE_BIT]) begin
                  s_next.open = 4'h0;
               end else begin
                  s_next.open[bsel] = 1'b0;
               end
            end
            sdc_pkg::SDC_CMD_RD, sdc_pkg::SDC_CMD_WR: begin
               s_next.busy = 1'b1;
               s_next.wr = !bus.we_n;
               s_next.bank = bsel;
               s_next.col = bus.addr[7:0];
               s_next.step = 8'h00;
               s_next.auto_pre = bus.addr[sdc_pkg::PRE_BIT];
            end
            sdc_pkg::SDC_CMD_BST: begin
               s_next.busy = 1'b0;
            end
            sdc_pkg::SDC_CMD_MRS: begin
               s_next.mode = bus.addr;
            end
            default: begin
            end
         endcase
         // Masks sampled a cycle before data leaves gate the drivers
         s_next.out_oe = 2'h0;
         if (cl == 3'h3 ? s_reg.rpipe[1][17] : s_reg.rpipe[0][17]) begin
            s_next.out_d = cl == 3'h3 ? s_reg.rpipe[1][15:0] : s_reg.rpipe[0][15:0];
            s_next.out_oe = {!bus.high_byte_mask, !bus.low_byte_mask};
         end
      end
      s_next.open_q = s_next.open;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.mode <= sdc_pkg::MODE_RESET;
      end else begin
         s_reg <= s_next;
      end
   end
   // Per-byte writes, each lane blocked by its mask
   for (genvar b = 0; b < 2; b++) begin : g_lane
      always_ff @(posedge clk) begin
         if (do_write && !(b == 0 ? bus.low_byte_mask : bus.high_byte_mask)) begin
            mem_reg[idx][8*b +: 8] <= bus.data_lines[8*b +: 8];
         end
      end
   end
   assign bus.data_lines_mem = s_reg.out_d;
   assign bus.data_lines_mem_oe = s_reg.out_oe;
   assign bank_open = s_reg.open_q;
   assign power_down = s_reg.pd;
endmodule

// ---- hdl/sdc_ctl.sv ----
`timescale 1ns/1ps
module sdc_ctl (
   input wire logic clk,
   input wire logic rst,
   sdc_if.ctl bus,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata
);
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_WDATA = 4'h1;
   localparam logic [3:0] REG_RDATA = 4'h2;
   localparam logic [3:0] REG_STAT = 4'h3;
   // Command word: [3:0] code, [5:4] bank, [17:6] address, [19:18] masks, [20] oe
   typedef struct packed {
      logic [3:0] code;
      logic [1:0] bank;
      logic [11:0] a;
      logic [1:0] mask;
      logic oe;
      logic cke;
      logic [15:0] wd;
      logic [15:0] rdcap;
      logic [3:0] open;
      logic viol;
      logic [10:0] ref_cnt;
      logic ref_due;
      logic [31:0] rdata;
   } sdc_ctl_st_t;
   sdc_ctl_st_t s_reg;
   sdc_ctl_st_t s_next;
   logic [3:0] code_in;
   logic [1:0] bank_in;
   assign code_in = wdata[3:0];
   assign bank_in = wdata[5:4];
   always_comb begin
      s_next = s_reg;
      s_next.code = sdc_pkg::SDC_CMD_NOP;
      s_next.ref_cnt = s_reg.ref_cnt + 11'h001;
      if (s_reg.ref_cnt == sdc_pkg::REF_GAP) begin
         s_next.ref_cnt = 11'h000;
         s_next.ref_due = 1'b1;
      end
      s_next.rdcap = bus.data_lines;
      s_next.rdata = 32'h00000000;
      if (wr) begin
         case (addr)
            REG_CMD: begin
               s_next.code = code_in;
               s_next.bank = bank_in;
               s_next.a = wdata[17:6];
               s_next.mask = wdata[19:18];
               s_next.oe = wdata[20];
               s_next.cke = !wdata[21];
               // Refuse illegal orders; a bad RD, WR or ACT goes out as NOP, a bad clock-enable drop leaves cke high
               if ((code_in == sdc_pkg::SDC_CMD_RD || code_in == sdc_pkg::SDC_CMD_WR)
                     && !s_reg.open[bank_in]) begin
                  s_next.code = sdc_pkg::SDC_CMD_NOP;
                  s_next.viol = 1'b1;
               end
               if (code_in == sdc_pkg::SDC_CMD_ACT && s_reg.open[bank_in]) begin
                  s_next.code = sdc_pkg::SDC_CMD_NOP;
                  s_next.viol = 1'b1;
               end
               if (wdata[21] && s_reg.open != 4'h0) begin
                  s_next.cke = 1'b1;
                  s_next.viol = 1'b1;
               end
               if (s_next.code == sdc_pkg::SDC_CMD_ACT) begin
                  s_next.open[bank_in] = 1'b1;
               end
               if (s_next.code == sdc_pkg::SDC_CMD_PRE) begin
                  if (wdata[6 + sdc_pkg::PRE_BIT]) begin
                     s_next.open = 4'h0;
                  end else begin
                     s_next.open[bank_in] = 1'b0;
                  end
               end
               // A new interval starting in the same cycle wins over the clear
               if (s_next.code == sdc_pkg::SDC_CMD_REF
                     && s_reg.ref_cnt != sdc_pkg::REF_GAP) begin
                  s_next.ref_due = 1'b0;
               end
            end
            REG_WDATA: s_next.wd = wdata[15:0];
            REG_STAT: begin
               if (wdata[4]) begin
                  s_next.viol = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end
      if (rd) begin
         case (addr)
            REG_RDATA: s_next.rdata = {16'h0000, s_reg.rdcap};
            REG_STAT: s_next.rdata = {25'h0000000, s_reg.ref_due, !s_reg.cke, s_reg.viol,
               s_reg.open};
            default: s_next.rdata = 32'h00000000;
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_reg <= '0;
         s_reg.code <= sdc_pkg::SDC_CMD_NOP;
         s_reg.cke <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end
   // All pins come from flops so they change right after the edge
   assign bus.cs_n = s_reg.code[3];
   assign bus.ras_n = s_reg.code[2];
   assign bus.cas_n = s_reg.code[1];
   assign bus.we_n = s_reg.code[0];
   assign bus.bank_sel_hi = s_reg.bank[1];
   assign bus.bank_sel_lo = s_reg.bank[0];
   assign bus.addr = s_reg.a;
   assign bus.high_byte_mask = s_reg.mask[1];
   assign bus.low_byte_mask = s_reg.mask[0];
   assign bus.cke = s_reg.cke;
   assign bus.data_lines_ctl = s_reg.wd;
   assign bus.data_lines_ctl_oe = s_reg.oe;
   assign rdata = s_reg.rdata;
endmodule

// ---- tb/sdc_monitor.sv ----
`timescale 1ns/1ps
module sdc_monitor (
   input wire logic clk,
   input wire logic rst,
   input wire logic cke,
   input wire logic cs_n,
   input wire logic ras_n,
   input wire logic cas_n,
   input wire logic we_n,
   input wire logic bank_sel_lo,
   input wire logic bank_sel_hi,
   input wire logic [sdc_pkg::ROW_W-1:0] addr,
   input wire logic low_byte_mask,
   input wire logic high_byte_mask,
   input wire logic data_lines_ctl_oe,
   input wire logic [1:0] data_lines_mem_oe
);
   logic [3:0] cmd;
   logic [1:0] bank;
   logic [3:0] open_reg;
   logic [6:0] mode_reg;
   logic quiet;
   logic clear;
   assign cmd = {cs_n, ras_n, cas_n, we_n};
   assign bank = {bank_sel_hi, bank_sel_lo};
   assign quiet = data_lines_mem_oe == 2'h0;
   assign clear = !low_byte_mask && !high_byte_mask;
   // Bank state seen on the wire; auto precharge is not tracked
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         open_reg <= 4'h0;
         mode_reg <= 7'h20;
      end else begin
         if (cmd == 4'h3) open_reg[bank] <= 1'b1;
         if (cmd == 4'h2) open_reg[bank] <= 1'b0;
         if (cmd == 4'h2 && addr[10]) open_reg <= 4'h0;
         if (cmd == 4'h0) mode_reg <= addr[6:0];
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   AST_ONE_DRIVER: assert property (!(data_lines_ctl_oe && !quiet))
      else $error("both ends drive data");
   AST_CL2_BL1: assert property (cmd == 4'h5 && clear && mode_reg == 7'h20 |->
      ##1 quiet [*2] ##1 data_lines_mem_oe == 2'h3 ##1 quiet) else $error("latency two wrong");
   AST_CL3_BL1: assert property (cmd == 4'h5 && clear && mode_reg == 7'h30 |->
      ##1 quiet [*3] ##1 data_lines_mem_oe == 2'h3 ##1 quiet) else $error("latency three wrong");
   AST_BL2: assert property (cmd == 4'h5 && clear && mode_reg == 7'h21 |->
      ##1 quiet [*2] ##1 data_lines_mem_oe == 2'h3 [*2] ##1 quiet) else $error("burst two wrong");
   AST_READ_MASK: assert property (cmd == 4'h5 && low_byte_mask && !high_byte_mask
      && mode_reg == 7'h20 |-> ##3 data_lines_mem_oe == 2'h2) else $error("read mask ignored");
   AST_DESELECT: assert property (cmd == 4'hD |-> ##1 quiet [*3])
      else $error("deselected command acted");
   AST_WRITE_QUIET: assert property (cmd == 4'h4 |-> quiet [*4])
      else $error("memory drove during write");
   AST_COL_OPEN: assert property (cmd == 4'h5 || cmd == 4'h4 |-> open_reg[bank])
      else $error("column access to idle bank");
   AST_ACT_IDLE: assert property (cmd == 4'h3 |-> !open_reg[bank])
      else $error("activate of open bank");
   AST_CKE_IDLE: assert property ($fell(cke) |-> open_reg == 4'h0)
      else $error("clock enable dropped with open bank");
   AST_FREEZE: assert property (!cke |=> $stable(data_lines_mem_oe))
      else $error("outputs moved while suspended");
   cover property (cmd == 4'h5);
   cover property (cmd == 4'h4);
   cover property ($fell(cke));
endmodule

// ---- tb/tb_sdram_command_interface.sv ----
`timescale 1ns/1ps
`define CHK(exp, got) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) begin \
         fails++; \
         $display("ERROR rdata expected %h seen %h", exp, got); \
      end \
   end
module tb_sdram_command_interface;
   logic clk, rst, wr, rd, power_down;
   logic [3:0] addr, bank_open;
   logic [31:0] wdata, rdata;
   int fails = 0;
   int comparisons = 0;
   sdc_if sif ();
   sdc_mem i_sdc_mem (.clk(clk), .rst(rst), .bus(sif), .bank_open(bank_open),
      .power_down(power_down));
   sdc_ctl i_sdc_ctl (.clk(clk), .rst(rst), .bus(sif), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata));
   sdc_monitor i_sdc_monitor (.clk(clk), .rst(rst), .cke(sif.cke), .cs_n(sif.cs_n),
      .ras_n(sif.ras_n), .cas_n(sif.cas_n), .we_n(sif.we_n), .addr(sif.addr),
      .bank_sel_lo(sif.bank_sel_lo), .bank_sel_hi(sif.bank_sel_hi),
      .low_byte_mask(sif.low_byte_mask), .high_byte_mask(sif.high_byte_mask),
      .data_lines_ctl_oe(sif.data_lines_ctl_oe), .data_lines_mem_oe(sif.data_lines_mem_oe));
   function automatic logic [31:0] cw(input logic [3:0] c, input logic [1:0] b,
      input logic [11:0] a, input logic [1:0] m, input logic oe, input logic lo);
      return {10'h000, lo, oe, m, a, b, c};
   endfunction
   task automatic wreg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      `CHK(exp, rdata[15:0])
   endtask
   // Waits the latency so the capture lands on the first beat
   task automatic col_rd(input logic [3:0] c, input logic [1:0] b, input logic [7:0] col,
      input logic [1:0] m, input int cl, input logic [15:0] exp);
      wreg(4'h0, cw(c, b, {4'h0, col}, m, 1'b0, 1'b0));
      // One more edge: the capture register lags the pins by a cycle
      repeat (cl + 1) @(posedge clk);
      rreg(4'h2, exp);
   endtask
   task automatic conclude;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #200000;
      fails++;
      conclude();
   end
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 4'h0;
      wdata = 32'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      rreg(4'h3, 16'h0000);
      for (int b = 0; b < 4; b++) begin
         wreg(4'h0, cw(4'h3, 2'(b), 12'h000, 2'h0, 1'b0, 1'b0));
      end
      rreg(4'h3, 16'h000F);
      wreg(4'h0, cw(4'h3, 2'h0, 12'h000, 2'h0, 1'b0, 1'b0));
      wreg(4'h0, cw(4'h7, 2'h0, 12'h000, 2'h0, 1'b0, 1'b1));
      rreg(4'h3, 16'h001F);
      wreg(4'h3, 32'h10);
      for (int b = 0; b < 4; b++) begin
         wreg(4'h1, 32'(16'hA500 + 16'(b)));
         wreg(4'h0, cw(4'h4, 2'(b), 12'(8'h10 + 4 * b), 2'h0, 1'b1, 1'b0));
      end
      for (int b = 0; b < 4; b++) begin
         col_rd(4'h5, 2'(b), 8'(8'h10 + 4 * b), 2'h0, 2, 16'hA500 + 16'(b));
      end
      wreg(4'h1, 32'h1234);
      wreg(4'h0, cw(4'h4, 2'h0, 12'h010, 2'h2, 1'b1, 1'b0));
      col_rd(4'h5, 2'h0, 8'h10, 2'h1, 2, 16'hA500);
      col_rd(4'h5, 2'h0, 8'h10, 2'h0, 2, 16'hA534);
      col_rd(4'hD, 2'h0, 8'h10, 2'h0, 2, 16'h0000);
      wreg(4'h0, cw(4'h2, 2'h2, 12'h000, 2'h0, 1'b0, 1'b0));
      rreg(4'h3, 16'h000B);
      wreg(4'h0, cw(4'h2, 2'h0, 12'h400, 2'h0, 1'b0, 1'b0));
      rreg(4'h3, 16'h0000);
      col_rd(4'h5, 2'h3, 8'h1C, 2'h0, 2, 16'h0000);
      rreg(4'h3, 16'h0010);
      wreg(4'h3, 32'h10);
      wreg(4'h0, cw(4'h0, 2'h0, 12'h030, 2'h0, 1'b0, 1'b0));
      wreg(4'h0, cw(4'h3, 2'h1, 12'h000, 2'h0, 1'b0, 1'b0));
      col_rd(4'h5, 2'h1, 8'h14, 2'h0, 3, 16'hA501);
      wreg(4'h0, cw(4'h2, 2'h0, 12'h400, 2'h0, 1'b0, 1'b0));
      wreg(4'h0, cw(4'h0, 2'h0, 12'h021, 2'h0, 1'b0, 1'b0));
      wreg(4'h0, cw(4'h3, 2'h1, 12'h000, 2'h0, 1'b0, 1'b0));
      col_rd(4'h5, 2'h1, 8'h14, 2'h0, 2, 16'hA501);
      wreg(4'h0, cw(4'h2, 2'h0, 12'h400, 2'h0, 1'b0, 1'b0));
      wreg(4'h0, cw(4'h7, 2'h0, 12'h000, 2'h0, 1'b0, 1'b1));
      rreg(4'h3, 16'h0020);
      wreg(4'h0, cw(4'h7, 2'h0, 12'h000, 2'h0, 1'b0, 1'b0));
      rreg(4'h3, 16'h0000);
      wreg(4'h0, cw(4'h1, 2'h0, 12'h000, 2'h0, 1'b0, 1'b0));
      wreg(4'h0, cw(4'h3, 2'h0, 12'h000, 2'h0, 1'b0, 1'b0));
      col_rd(4'h5, 2'h0, 8'h10, 2'h0, 2, 16'hA534);
      conclude();
   end
endmodule
